// ===== src/ivmap_pkg.sv
// constants shared by the interrupt vector map
package ivmap_pkg;
    // peripheral interrupt numbers 16..63, one level register each
    localparam int NUM_PERIPH = 48;
    localparam logic [7:0] FIRST_PERIPH = 8'h10;
    // fixed exception numbers
    localparam logic [7:0] NUM_INSTR_PROT = 8'h06;
    localparam logic [7:0] NUM_DATA_PROT = 8'h07;
    localparam logic [7:0] NUM_DATA_ERR = 8'h08;
    localparam logic [7:0] NUM_ILLEGAL = 8'h0e;
    localparam logic [7:0] NUM_NMI = 8'h0f;
    localparam logic [7:0] NUM_TRAP_FIRST = 8'h42;
    // peripheral indices (number minus 16)
    localparam int IDX_LVD = 1;
    localparam int IDX_SER0_TX = 5;
    localparam int IDX_SER1_TX = 7;
    localparam int IDX_FLEXRAY0 = 15;
    localparam int IDX_FLEXRAY1 = 16;
    localparam int IDX_FR_TIMER0 = 17;
    localparam int IDX_FR_TIMER1 = 18;
    localparam int IDX_RAM_SHARED = 19;
    localparam int IDX_CNT_SHARED = 20;
    localparam int IDX_WAVE_SHARED = 39;
    // shared source counts
    localparam int RAM_SRC_N = 10;
    localparam int CNT_SRC_N = 5;
    localparam int WAVE_SRC_N = 8;
    localparam int NMI_SRC_N = 6;
    // vector offset of number 0; each number steps down one word
    localparam logic [9:0] VEC_TOP = 10'h3fc;
    // levels
    localparam logic [4:0] LVL_NMI = 5'h0f;
    localparam logic [4:0] LVL_EXC = 5'h00;
    localparam logic [4:0] LVL_MASKED = 5'h1f;
    localparam logic [4:0] LVL_RESET = 5'h1f;
    // numbers that carry a dma resource number (index = number - 16)
    localparam logic [47:0] RES_NUM_PRESENT = 48'h3fff_ffc3_ffff;
    // register map (byte addresses)
    localparam logic [11:0] REG_VEC_BASE = 12'h000;
    localparam logic [11:0] REG_DMA_EN_LO = 12'h004;
    localparam logic [11:0] REG_DMA_EN_HI = 12'h008;
    localparam logic [11:0] REG_STATUS = 12'h00c;
    localparam logic [11:0] REG_VECTOR = 12'h010;
    localparam logic [11:0] REG_LEVEL_BASE = 12'h100;
    localparam logic [11:0] REG_LEVEL_END = 12'h1c0;
    // reset values
    localparam logic [31:0] VEC_BASE_RESET = 32'h000f_fc00;
    localparam logic [47:0] DMA_EN_RESET = 48'h0000_0000_0000;
    // status register fields
    localparam int STAT_VALID_BIT = 31;
    localparam int STAT_DMA_BIT = 30;
    localparam int STAT_LVL_LSB = 8;
endpackage

// ===== src/ivmap_top.sv
// interrupt vector map with level registers and dma gating
`timescale 1ns/100ps

// Notes on behaviour
// - numbers 66..255 are software trap vectors down to the table base.
// - illegal instruction is number 14, fixed level, offset 3c4.
// - nmi, bus diag, ram double-bit and timing violation form number 15, level 15.
// - instruction protection is number 6, data protection number 7.
// - data access error is number 8, no programmable level.
// - low-voltage detection is number 17, level from level register 1.
// - serial 0 transmit done is number 21, level register 5, resource 5.
// - serial 1 transmit done is number 23, level register 7, resource 7.
// - number 35 shares ram events and one can channel, no resource.
// - number 36 shares pll, up/down counters and two can channels.
// - number 55 shares dead timer, stop input and capture, register 39.
// - dma requests only from numbers that carry a resource number.
// - serial status from i2c reception or flexray never starts dma.
// - reload timer channels 4 to 7 never start dma.
// - pulse generator channels 24 to 87 never start dma.
// - clock calibration interrupts never start dma.
// - 32-bit free-run timer channels 3 to 10 never start dma.
// - low-voltage detection never starts dma.
// - flexray controller interrupts never start dma.
// - flexray timer interrupts never start dma.
module ivmap_top
    import ivmap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // exception sources
    input wire logic instr_prot_exc,
    input wire logic data_prot_exc,
    input wire logic data_err_exc,
    input wire logic illegal_exc,
    input wire logic [NMI_SRC_N-1:0] nmi_src,
    // peripheral sources, index = number - 16
    input wire logic [NUM_PERIPH-1:0] periph_irq,
    input wire logic [NUM_PERIPH-1:0] periph_irq_nodma,
    input wire logic lvd_irq,
    input wire logic [1:0] flexray_irq,
    input wire logic [1:0] flexray_timer_irq,
    input wire logic [RAM_SRC_N-1:0] ram_shared_irq,
    input wire logic [CNT_SRC_N-1:0] cnt_shared_irq,
    input wire logic [WAVE_SRC_N-1:0] wave_shared_irq,
    // software trap lookup
    input wire logic trap_valid,
    input wire logic [7:0] trap_num,
    output logic trap_vec_valid,
    output logic [31:0] trap_vec_addr,
    // to cpu core
    output logic cpu_irq_req,
    output logic [7:0] cpu_irq_num,
    output logic [4:0] cpu_irq_level,
    output logic [31:0] cpu_vec_addr,
    // to dma controller
    output logic dma_req,
    output logic [5:0] dma_res_num
);

    function automatic logic [31:0] vec_addr(input logic [31:0] base, input logic [7:0] num);
        vec_addr = base + {22'h0, VEC_TOP - {num, 2'b00}};
    endfunction

    // reset synchroniser
    logic rst_meta_reg;
    logic rst_sync_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_sync_reg <= rst_meta_reg;
        end
    end

    // register state
    logic [31:0] vec_base_reg;
    logic [31:0] vec_base_next;
    logic [47:0] dma_en_reg;
    logic [47:0] dma_en_next;
    logic [4:0] level_reg [NUM_PERIPH];
    logic [4:0] level_next [NUM_PERIPH];
    logic wr_pend_reg;
    logic wr_pend_next;
    logic [11:0] wr_addr_reg;
    logic [11:0] wr_addr_next;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic hreadyout_reg;

    // delivery state
    logic irq_req_reg;
    logic irq_req_next;
    logic [7:0] irq_num_reg;
    logic [7:0] irq_num_next;
    logic [4:0] irq_lvl_reg;
    logic [4:0] irq_lvl_next;
    logic [31:0] irq_vec_reg;
    logic [31:0] irq_vec_next;
    logic dma_req_reg;
    logic dma_req_next;
    logic [5:0] dma_num_reg;
    logic [5:0] dma_num_next;
    logic trap_ok_reg;
    logic trap_ok_next;
    logic [31:0] trap_addr_reg;
    logic [31:0] trap_addr_next;

    logic [NUM_PERIPH-1:0] periph_pend;
    logic [NUM_PERIPH-1:0] dma_src;
    logic accept;
    logic [5:0] lvl_idx;
    logic [11:0] lvl_off;

    // source merging per number
    always_comb begin
        periph_pend = periph_irq | periph_irq_nodma;
        periph_pend[IDX_LVD] = periph_irq[IDX_LVD] | periph_irq_nodma[IDX_LVD] | lvd_irq;
        periph_pend[IDX_FLEXRAY0] = periph_irq[IDX_FLEXRAY0] | periph_irq_nodma[IDX_FLEXRAY0]
            | flexray_irq[0];
        periph_pend[IDX_FLEXRAY1] = periph_irq[IDX_FLEXRAY1] | periph_irq_nodma[IDX_FLEXRAY1]
            | flexray_irq[1];
        periph_pend[IDX_FR_TIMER0] = periph_irq[IDX_FR_TIMER0] | periph_irq_nodma[IDX_FR_TIMER0]
            | flexray_timer_irq[0];
        periph_pend[IDX_FR_TIMER1] = periph_irq[IDX_FR_TIMER1] | periph_irq_nodma[IDX_FR_TIMER1]
            | flexray_timer_irq[1];
        // any source of a shared number raises it
        periph_pend[IDX_RAM_SHARED] = periph_irq[IDX_RAM_SHARED]
            | periph_irq_nodma[IDX_RAM_SHARED] | (|ram_shared_irq);
        periph_pend[IDX_CNT_SHARED] = periph_irq[IDX_CNT_SHARED]
            | periph_irq_nodma[IDX_CNT_SHARED] | (|cnt_shared_irq);
        periph_pend[IDX_WAVE_SHARED] = periph_irq[IDX_WAVE_SHARED]
            | periph_irq_nodma[IDX_WAVE_SHARED] | (|wave_shared_irq);
        // only dma-capable sources on numbers with a resource number
        // excluded sources (i2c status, reload 4-7, pulse_generator 24-87, calibration,
        // 32-bit timers 3-10) arrive on periph_irq_nodma and never reach dma
        dma_src = periph_irq & RES_NUM_PRESENT
            & dma_en_reg;
        // lvd and flexray lines are kept out of dma_src entirely
    end

    // bus slave
    assign accept = hsel & hready & htrans[1];
    assign lvl_off = haddr[11:0] - REG_LEVEL_BASE;
    assign lvl_idx = lvl_off[7:2];

    always_comb begin
        wr_pend_next = accept & hwrite;
        wr_addr_next = accept ? haddr[11:0] : wr_addr_reg;
        hrdata_next = 32'h0000_0000;
        vec_base_next = vec_base_reg;
        dma_en_next = dma_en_reg;
        if (accept && !hwrite && haddr[1:0] == 2'b00) begin
            if (haddr[11:0] == REG_VEC_BASE) begin
                hrdata_next = vec_base_reg;
            end else if (haddr[11:0] == REG_DMA_EN_LO) begin
                hrdata_next = dma_en_reg[31:0];
            end else if (haddr[11:0] == REG_DMA_EN_HI) begin
                hrdata_next = {16'h0000, dma_en_reg[47:32]};
            end else if (haddr[11:0] == REG_STATUS) begin
                hrdata_next[STAT_VALID_BIT] = irq_req_reg;
                hrdata_next[STAT_DMA_BIT] = dma_req_reg;
                hrdata_next[STAT_LVL_LSB +: 5] = irq_lvl_reg;
                hrdata_next[7:0] = irq_num_reg;
            end else if (haddr[11:0] == REG_VECTOR) begin
                hrdata_next = irq_vec_reg;
            end else if (haddr[11:0] >= REG_LEVEL_BASE && haddr[11:0] < REG_LEVEL_END) begin
                hrdata_next = {27'h0, level_reg[lvl_idx]};
            end
        end
        if (wr_pend_reg) begin
            if (wr_addr_reg == REG_VEC_BASE) begin
                vec_base_next = {hwdata[31:2], 2'b00};
            end else if (wr_addr_reg == REG_DMA_EN_LO) begin
                dma_en_next[31:0] = hwdata;
            end else if (wr_addr_reg == REG_DMA_EN_HI) begin
                dma_en_next[47:32] = hwdata[15:0];
            end
        end
    end

    // one level register per peripheral number
    for (genvar g = 0; g < NUM_PERIPH; g++) begin : g_level
        always_comb begin
            level_next[g] = level_reg[g];
            if (wr_pend_reg && wr_addr_reg == REG_LEVEL_BASE + 12'(g * 4)) begin
                level_next[g] = hwdata[4:0];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 12'h000;
            hrdata_reg <= 32'h0000_0000;
            hreadyout_reg <= 1'b0;
            vec_base_reg <= VEC_BASE_RESET;
            dma_en_reg <= DMA_EN_RESET;
            for (int i = 0; i < NUM_PERIPH; i++) begin
                level_reg[i] <= LVL_RESET;
            end
        end else begin
            wr_pend_reg <= wr_pend_next;
            wr_addr_reg <= wr_addr_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            vec_base_reg <= vec_base_next;
            dma_en_reg <= dma_en_next;
            for (int i = 0; i < NUM_PERIPH; i++) begin
                level_reg[i] <= level_next[i];
            end
        end
    end

    // arbitration: exceptions in number order, then lowest level value
    always_comb begin
        irq_req_next = 1'b1;
        irq_num_next = 8'h00;
        irq_lvl_next = LVL_EXC;
        dma_req_next = 1'b0;
        dma_num_next = 6'h00;
        if (instr_prot_exc) begin
            irq_num_next = NUM_INSTR_PROT;
        end else if (data_prot_exc) begin
            irq_num_next = NUM_DATA_PROT;
        end else if (data_err_exc) begin
            irq_num_next = NUM_DATA_ERR;
        end else if (illegal_exc) begin
            irq_num_next = NUM_ILLEGAL;
        end else if (|nmi_src) begin
            irq_num_next = NUM_NMI;
            irq_lvl_next = LVL_NMI;
        end else begin
            irq_req_next = 1'b0;
            irq_lvl_next = LVL_MASKED;
            for (int i = 0; i < NUM_PERIPH; i++) begin
                // serial 0/1 transmit and lvd use their own level register index
                if (periph_pend[i] && level_reg[i] != LVL_MASKED
                    && (!irq_req_next || level_reg[i] < irq_lvl_next)) begin
                    irq_req_next = 1'b1;
                    irq_num_next = FIRST_PERIPH + 8'(i);
                    irq_lvl_next = level_reg[i];
                end
            end
            if (!irq_req_next) begin
                irq_lvl_next = LVL_EXC;
            end
        end
        irq_vec_next = vec_addr(vec_base_reg, irq_num_next);
        // dma resource number equals the peripheral index
        for (int i = NUM_PERIPH - 1; i >= 0; i--) begin
            if (dma_src[i]) begin
                dma_req_next = 1'b1;
                dma_num_next = 6'(i);
            end
        end
        trap_ok_next = trap_valid && trap_num >= NUM_TRAP_FIRST;
        trap_addr_next = trap_ok_next ? vec_addr(vec_base_reg, trap_num)
            : trap_addr_reg;
    end

    always_ff @(posedge clk or negedge rst_sync_reg) begin
        if (!rst_sync_reg) begin
            irq_req_reg <= 1'b0;
            irq_num_reg <= 8'h00;
            irq_lvl_reg <= LVL_EXC;
            irq_vec_reg <= VEC_BASE_RESET;
            dma_req_reg <= 1'b0;
            dma_num_reg <= 6'h00;
            trap_ok_reg <= 1'b0;
            trap_addr_reg <= VEC_BASE_RESET;
        end else begin
            irq_req_reg <= irq_req_next;
            irq_num_reg <= irq_num_next;
            irq_lvl_reg <= irq_lvl_next;
            irq_vec_reg <= irq_vec_next;
            dma_req_reg <= dma_req_next;
            dma_num_reg <= dma_num_next;
            trap_ok_reg <= trap_ok_next;
            trap_addr_reg <= trap_addr_next;
        end
    end

    // outputs
    assign hrdata = hrdata_reg;
    assign hreadyout = hreadyout_reg;
    assign hresp = 1'b0;
    assign cpu_irq_req = irq_req_reg;
    assign cpu_irq_num = irq_num_reg;
    assign cpu_irq_level = irq_lvl_reg;
    assign cpu_vec_addr = irq_vec_reg;
    assign dma_req = dma_req_reg;
    assign dma_res_num = dma_num_reg;
    assign trap_vec_valid = trap_ok_reg;
    assign trap_vec_addr = trap_addr_reg;

endmodule

// ===== test/ivmap_asserts.sv
// port assertions for the interrupt vector map
`timescale 1ns/100ps
module ivmap_asserts
    import ivmap_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // sources
    input wire logic instr_prot_exc,
    input wire logic data_prot_exc,
    input wire logic data_err_exc,
    input wire logic illegal_exc,
    input wire logic [NMI_SRC_N-1:0] nmi_src,
    input wire logic [NUM_PERIPH-1:0] periph_irq,
    input wire logic [NUM_PERIPH-1:0] periph_irq_nodma,
    input wire logic lvd_irq,
    input wire logic [1:0] flexray_irq,
    input wire logic [1:0] flexray_timer_irq,
    input wire logic trap_valid,
    input wire logic [7:0] trap_num,
    // results
    input wire logic trap_vec_valid,
    input wire logic [31:0] trap_vec_addr,
    input wire logic cpu_irq_req,
    input wire logic [7:0] cpu_irq_num,
    input wire logic [4:0] cpu_irq_level,
    input wire logic [31:0] cpu_vec_addr,
    input wire logic dma_req,
    input wire logic [5:0] dma_res_num
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_trap_hit: assert property (trap_valid && trap_num >= NUM_TRAP_FIRST
        |=> trap_vec_valid)
        else $error("trap lookup not answered");
    chk_trap_miss: assert property (trap_valid && trap_num < NUM_TRAP_FIRST
        |=> !trap_vec_valid)
        else $error("trap lookup below trap range");
    chk_vec_base: assert property (trap_vec_valid && cpu_irq_req
        |-> (cpu_vec_addr + (32'(cpu_irq_num) << 2))
        == (trap_vec_addr + (32'($past(trap_num)) << 2)))
        else $error("vector offsets disagree");
    chk_instr_first: assert property (instr_prot_exc
        |=> cpu_irq_req && cpu_irq_num == NUM_INSTR_PROT && cpu_irq_level == LVL_EXC)
        else $error("instruction protection not number 6");
    chk_data_prot: assert property (data_prot_exc && !instr_prot_exc
        |=> cpu_irq_num == NUM_DATA_PROT)
        else $error("data protection not number 7");
    chk_data_err: assert property (
        {data_err_exc, data_prot_exc, instr_prot_exc} == 3'h4
        |=> cpu_irq_num == NUM_DATA_ERR && cpu_irq_level == LVL_EXC)
        else $error("data error not number 8");
    chk_illegal_num: assert property (
        {illegal_exc, data_err_exc, data_prot_exc, instr_prot_exc} == 4'h8
        |=> cpu_irq_num == NUM_ILLEGAL && cpu_irq_level == LVL_EXC)
        else $error("illegal instruction not number 14");
    chk_nmi_fixed: assert property (
        {illegal_exc, data_err_exc, data_prot_exc, instr_prot_exc} == 4'h0 && (|nmi_src)
        |=> cpu_irq_num == NUM_NMI && cpu_irq_level == LVL_NMI)
        else $error("nmi group not number 15 level 15");
    chk_dma_num_ok: assert property (dma_req
        |-> dma_res_num < 6'd48 && RES_NUM_PRESENT[dma_res_num]
        && ((($past(periph_irq) >> dma_res_num) & 48'h1) != 48'h0))
        else $error("dma request without resource number");
    chk_dma_quiet: assert property (periph_irq == '0
        |=> !dma_req)
        else $error("dma request from a non dma source");
    chk_nodma_src: assert property (
        periph_irq == '0 && (lvd_irq || (|flexray_irq) || (|flexray_timer_irq)
        || (|periph_irq_nodma)) |=> !dma_req)
        else $error("dma request from an excluded source");
endmodule
bind ivmap_top ivmap_asserts chk_u (.clk(clk), .rstn(rstn), .instr_prot_exc(instr_prot_exc),
    .data_prot_exc(data_prot_exc), .data_err_exc(data_err_exc), .illegal_exc(illegal_exc),
    .nmi_src(nmi_src), .periph_irq(periph_irq), .periph_irq_nodma(periph_irq_nodma),
    .lvd_irq(lvd_irq), .flexray_irq(flexray_irq), .flexray_timer_irq(flexray_timer_irq),
    .trap_valid(trap_valid), .trap_num(trap_num),
    .trap_vec_valid(trap_vec_valid), .trap_vec_addr(trap_vec_addr), .cpu_irq_req(cpu_irq_req),
    .cpu_irq_num(cpu_irq_num), .cpu_irq_level(cpu_irq_level), .cpu_vec_addr(cpu_vec_addr),
    .dma_req(dma_req), .dma_res_num(dma_res_num));

// ===== test/ivmap_core_model.sv
// cpu entry stand-in that latches the vector it is handed
`timescale 1ns/100ps
module ivmap_core_model (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // request from the map
    input wire logic cpu_irq_req,
    input wire logic [31:0] cpu_vec_addr,
    // vector taken at entry
    output logic [31:0] entry_vec
);
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            entry_vec <= 32'h0;
        end else if (cpu_irq_req) begin
            entry_vec <= cpu_vec_addr;
        end
    end
endmodule

// ===== test/testbench.sv
// self-checking bench for the interrupt vector map
`timescale 1ns/100ps
module testbench;
    import ivmap_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic [3:0] exc = 4'h0;
    logic [NMI_SRC_N-1:0] nmi = '0;
    logic [NUM_PERIPH-1:0] pirq = '0;
    logic [NUM_PERIPH-1:0] pnod = '0;
    logic lvd = 1'b0;
    logic [1:0] frx = 2'h0;
    logic [1:0] frt = 2'h0;
    logic [RAM_SRC_N-1:0] ram = '0;
    logic [CNT_SRC_N-1:0] cnt = '0;
    logic [WAVE_SRC_N-1:0] wave = '0;
    logic tv = 1'b0;
    logic [7:0] tn = 8'h0;
    logic [31:0] hrdata, trap_vec_addr, cpu_vec_addr, entry_vec, rd;
    logic hreadyout, hresp, trap_vec_valid, cpu_irq_req, dma_req;
    logic [7:0] cpu_irq_num;
    logic [4:0] cpu_irq_level;
    logic [5:0] dma_res_num;
    logic [31:0] vbase = VEC_BASE_RESET;
    int n_mismatch = 0;
    int samples_checked = 0;
    always #5 clk = ~clk;
    ivmap_top dut_u (.clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .instr_prot_exc(exc[0]), .data_prot_exc(exc[1]),
        .data_err_exc(exc[2]), .illegal_exc(exc[3]), .nmi_src(nmi), .periph_irq(pirq),
        .periph_irq_nodma(pnod), .lvd_irq(lvd), .flexray_irq(frx), .flexray_timer_irq(frt),
        .ram_shared_irq(ram), .cnt_shared_irq(cnt), .wave_shared_irq(wave), .trap_valid(tv),
        .trap_num(tn), .trap_vec_valid(trap_vec_valid), .trap_vec_addr(trap_vec_addr),
        .cpu_irq_req(cpu_irq_req), .cpu_irq_num(cpu_irq_num), .cpu_irq_level(cpu_irq_level),
        .cpu_vec_addr(cpu_vec_addr), .dma_req(dma_req), .dma_res_num(dma_res_num));
    ivmap_core_model core_u (.clk(clk), .rstn(rstn), .cpu_irq_req(cpu_irq_req),
        .cpu_vec_addr(cpu_vec_addr), .entry_vec(entry_vec));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic results();
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic wait_rdy();
        int i;
        i = 0;
        do begin
            @(posedge clk);
            i++;
        end while (hreadyout !== 1'b1 && i < 100);
        if (i >= 100) begin
            n_mismatch++;
            $display("mismatch at %0t: bus hang", $time);
            results();
        end
    endtask
    task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        haddr <= {20'h0, a};
        hsel <= 1'b1;
        hwrite <= wr;
        htrans <= 2'b10;
        wait_rdy();
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
    endtask
    function automatic logic [31:0] vec(input logic [7:0] n);
        return vbase + 32'h3fc - {22'h0, n, 2'b00};
    endfunction
    task automatic see(input logic [7:0] n, input logic [4:0] l);
        check({31'h0, cpu_irq_req}, 32'h1);
        check({24'h0, cpu_irq_num}, {24'h0, n});
        check({27'h0, cpu_irq_level}, {27'h0, l});
        check(cpu_vec_addr, vec(n));
    endtask
    task automatic t_regs();
        bus(1'b0, REG_VEC_BASE, 32'h0);
        check(rd, VEC_BASE_RESET);
        check({31'h0, hresp}, 32'h0);
        bus(1'b0, REG_LEVEL_BASE, 32'h0);
        check(rd, 32'h1f);
        bus(1'b1, 12'h200, 32'hffff_ffff);
        bus(1'b0, 12'h200, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, REG_VEC_BASE, 32'h0001_0003);
        vbase = 32'h0001_0000;
        bus(1'b0, REG_VEC_BASE, 32'h0);
        check(rd, vbase);
    endtask
    task automatic t_trap();
        int lst[4] = '{65, 66, 130, 255};
        tv <= 1'b1;
        foreach (lst[k]) begin
            tn <= 8'(lst[k]);
            settle();
            check({31'h0, trap_vec_valid}, {31'h0, lst[k] >= 66});
            if (lst[k] >= 66) begin
                check(trap_vec_addr, vec(8'(lst[k])));
            end
        end
        tv <= 1'b0;
    endtask
    task automatic t_exc();
        logic [3:0] m[6] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h0, 4'hf};
        logic [7:0] nu[6] = '{NUM_INSTR_PROT, NUM_DATA_PROT, NUM_DATA_ERR, NUM_ILLEGAL, NUM_NMI,
            NUM_INSTR_PROT};
        tv <= 1'b1;
        tn <= 8'd200;
        for (int k = 0; k < 6; k++) begin
            exc <= m[k];
            nmi <= (k >= 4) ? NMI_SRC_N'(1) << k : '0;
            settle();
            see(nu[k], (k == 4) ? LVL_NMI : LVL_EXC);
        end
        exc <= 4'h0;
        nmi <= '0;
        tv <= 1'b0;
    endtask
    task automatic t_periph();
        bus(1'b1, REG_LEVEL_BASE + 12'h14, 32'h14);
        bus(1'b1, REG_LEVEL_BASE + 12'h1c, 32'h03);
        bus(1'b1, REG_DMA_EN_LO, 32'h0000_00a0);
        pirq <= 48'h20;
        settle();
        see(8'd21, 5'h14);
        check({25'h0, dma_req, dma_res_num}, {25'h0, 1'b1, 6'd5});
        pirq <= 48'ha0;
        settle();
        see(8'd23, 5'h03);
        check({25'h0, dma_req, dma_res_num}, {25'h0, 1'b1, 6'd5});
        @(posedge clk);
        check(entry_vec, vec(8'd23));
        bus(1'b0, REG_STATUS, 32'h0);
        check(rd, 32'hc000_0317);
        bus(1'b0, REG_VECTOR, 32'h0);
        check(rd, vec(8'd23));
        bus(1'b1, REG_DMA_EN_LO, 32'h0000_0080);
        settle();
        check({25'h0, dma_req, dma_res_num}, {25'h0, 1'b1, 6'd7});
        pirq <= '0;
    endtask
    task automatic t_nodma();
        bus(1'b1, REG_LEVEL_BASE + 12'h04, 32'h04);
        bus(1'b1, REG_DMA_EN_LO, 32'hffff_ffff);
        bus(1'b1, REG_DMA_EN_HI, 32'h0000_ffff);
        bus(1'b0, REG_DMA_EN_HI, 32'h0);
        check(rd, 32'h0000_ffff);
        lvd <= 1'b1;
        settle();
        see(8'd17, 5'h04);
        check({31'h0, dma_req}, 32'h0);
        lvd <= 1'b0;
        frx <= 2'h3;
        frt <= 2'h3;
        settle();
        check({31'h0, dma_req}, 32'h0);
        frx <= 2'h0;
        frt <= 2'h0;
        pnod <= '1;
        settle();
        check({31'h0, dma_req}, 32'h0);
        pnod <= '0;
        pirq <= 48'h8_0000;
        settle();
        check({31'h0, dma_req}, 32'h0);
        pirq <= '0;
    endtask
    task automatic t_shared();
        bus(1'b1, REG_LEVEL_BASE + 12'h4c, 32'h02);
        bus(1'b1, REG_LEVEL_BASE + 12'h50, 32'h06);
        bus(1'b1, REG_LEVEL_BASE + 12'h9c, 32'h09);
        for (int b = 0; b < RAM_SRC_N; b++) begin
            ram <= RAM_SRC_N'(1) << b;
            settle();
            see(8'd35, 5'h02);
        end
        ram <= '0;
        cnt <= CNT_SRC_N'(1) << 4;
        settle();
        see(8'd36, 5'h06);
        cnt <= '0;
        wave <= WAVE_SRC_N'(1) << 7;
        settle();
        see(8'd55, 5'h09);
        wave <= '0;
    endtask
    initial begin
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        wait_rdy();
        t_regs();
        t_trap();
        t_exc();
        t_periph();
        t_nodma();
        t_shared();
        results();
    end
endmodule
